// >>> tmr2_params.svh
`ifndef TMR2_PARAMS_SVH
`define TMR2_PARAMS_SVH

// register indices, byte address is four times the index
`define IDX_CTRL       8'hC8
`define IDX_MODE       8'hC9
`define IDX_CAP_LO     8'hCA
`define IDX_CAP_HI     8'hCB
`define IDX_CNT_LO     8'hCC
`define IDX_CNT_HI     8'hCD
`define IDX_CLKCTL     8'h8E
`define IDX_IRQEN      8'hA8

// field positions
`define MODE_DOWN_COUNT_ENABLE_BIT  0
`define MODE_CRST_BIT  3
`define CLKCTL_SPD_BIT 5
`define IRQEN_BIT      5
`define MODE_WR_MASK   8'h09

// reset values
`define CTRL_RST       8'h00
`define MODE_RST       8'h00
`define BYTE_RST       8'h00
`define CNT_ALL_ONES   16'hFFFF
`define CNT_ZERO       16'h0000

// divider limits, in clk_sys cycles per tick
`define DIV_SLOW       4'hC
`define DIV_FAST       4'h4
`define DIV_BAUD       4'h2

`endif

// >>> tmr2_pkg.sv
package tmr2_pkg;

  typedef struct packed {
    logic ovf;
    logic ext;
    logic rclk;
    logic transmit_clock_select;
    logic exen;
    logic run;
    logic cts;
    logic cpsel;
  } ctrl_s;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } word16_s;

endpackage

// >>> timer2_capture_reload_baud.sv
// Overview of operation
// - overflow flag sets when the 16-bit count overflows outside baud generator mode
// - down counting also sets overflow when count equals reload value
// - hardware sets overflow flag only while both clock selects are 0
// - hardware never clears overflow flag; software may set or clear it
// - event flag sets on trigger falling edge or overflow, per mode bits
// - event flag set by trigger edge stays until software clears it
// - software set or trigger edge raises timer interrupt when enabled
// - receive clock select picks timer 1 or own overflow in modes 1, 3
// - transmit clock select picks timer 1 or own overflow in modes 1, 3
// - either clock select forces baud generator mode
// - external enable lets trigger edges capture or reload, else ignored
// - run bit enables counting; clearing it holds the count except on trigger reload or capture reset
// - outside baud generator mode, timer mode counts internal ticks by speed bit; counter mode pin edges
// - baud generator mode advances once every two clocks
// - with a clock select set, reload on every overflow, ignore capture
// - reload mode reloads on overflow and, if enabled, on trigger edge
// - capture mode copies count into capture bytes on trigger edge
// - capture reset bit clears the count after a capture
// - down count enable with trigger level sets direction in reload mode
// - capture bytes take captured count and supply the reload value
//
// The APB slave port was decided locally.
`include "tmr2_params.svh"

module timer2_capture_reload_baud (
  input  wire logic        clk_sys,             // system clock
  input  wire logic        rst,                 // async reset, high
  input  wire logic        psel,                // apb select
  input  wire logic        penable,             // apb enable
  input  wire logic        pwrite,              // apb direction
  input  wire logic [11:0] paddr,               // apb byte address
  input  wire logic [31:0] pwdata,              // apb write data
  output logic      [31:0] prdata,              // apb read data
  output logic             pready,              // apb ready
  output logic             pslverr,             // apb error
  input  wire logic        external_trigger_pin, // trigger pin
  input  wire logic        external_count_pin,  // count pin
  input  wire logic [1:0]  serial_mode,         // serial port mode
  input  wire logic        timer1_overflow,     // timer 1 overflow pulse
  output logic             rx_baud_tick,        // receive baud pulse
  output logic             tx_baud_tick,        // transmit baud pulse
  output logic             timer_irq            // timer interrupt request
);

  ////////////////////////////////////////////////////////////////////////
  // register state

  tmr2_pkg::ctrl_s   ctrl_q;
  logic [7:0]        mode_q;
  tmr2_pkg::word16_s cap_q;
  tmr2_pkg::word16_s cnt_q;
  tmr2_pkg::word16_s cnt_d;
  logic              speed_q;
  logic              irq_en_q;

  ////////////////////////////////////////////////////////////////////////
  // apb decode

  logic        setup;
  logic        acc_wr;
  logic [7:0]  idx;
  logic        hit;
  logic [31:0] rd_d;
  logic        wr_ctrl;
  logic        wr_mode;
  logic        wr_cap_lo;
  logic        wr_cap_hi;
  logic        wr_cnt_lo;
  logic        wr_cnt_hi;
  logic        wr_clk;
  logic        wr_irq;

  assign setup  = psel & ~penable;
  assign acc_wr = psel & penable & pwrite & pready & ~pslverr;
  assign idx    = paddr[9:2];

  always_comb
  begin
    hit  = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    rd_d = 32'h0000_0000;
    unique case (idx)
      `IDX_CTRL:   rd_d[7:0] = ctrl_q;
      `IDX_MODE:   rd_d[7:0] = mode_q;
      `IDX_CAP_LO: rd_d[7:0] = cap_q.lo;
      `IDX_CAP_HI: rd_d[7:0] = cap_q.hi;
      `IDX_CNT_LO: rd_d[7:0] = cnt_q.lo;
      `IDX_CNT_HI: rd_d[7:0] = cnt_q.hi;
      `IDX_CLKCTL: rd_d[`CLKCTL_SPD_BIT] = speed_q;
      `IDX_IRQEN:  rd_d[`IRQEN_BIT] = irq_en_q;
      default:     hit = 1'b0;
    endcase
  end

  assign wr_ctrl   = acc_wr && (idx == `IDX_CTRL);
  assign wr_mode   = acc_wr && (idx == `IDX_MODE);
  assign wr_cap_lo = acc_wr && (idx == `IDX_CAP_LO);
  assign wr_cap_hi = acc_wr && (idx == `IDX_CAP_HI);
  assign wr_cnt_lo = acc_wr && (idx == `IDX_CNT_LO);
  assign wr_cnt_hi = acc_wr && (idx == `IDX_CNT_HI);
  assign wr_clk    = acc_wr && (idx == `IDX_CLKCTL);
  assign wr_irq    = acc_wr && (idx == `IDX_IRQEN);

  // answer one cycle after setup: zero wait states in the access phase
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      if (setup)
      begin
        prdata <= hit ? rd_d : 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: change counts once second and third stages agree

  logic [1:0] pin_in;
  logic [1:0] pin_lvl_q;
  logic [1:0] pin_fall;

  assign pin_in = {external_count_pin, external_trigger_pin};

  for (genvar g = 0; g < 2; g++)
  begin : g_pin
    logic [2:0] sync_q;
    always_ff @(posedge clk_sys or posedge rst)
    begin
      if (rst)
      begin
        sync_q       <= 3'h7;
        pin_lvl_q[g] <= 1'b1;
      end
      else
      begin
        sync_q <= {sync_q[1:0], pin_in[g]};
        if (sync_q[2] == sync_q[1])
        begin
          pin_lvl_q[g] <= sync_q[2];
        end
      end
    end
    assign pin_fall[g] = pin_lvl_q[g] & ~sync_q[2] & ~sync_q[1];
  end

  ////////////////////////////////////////////////////////////////////////
  // mode decode and tick divider

  logic       baud;
  logic       down_count_enable;
  logic       capres;
  logic       down_mode;
  logic       reload_mode;
  logic       dir_up;
  logic [3:0] div_q;
  logic [3:0] div_lim;
  logic       tick_en;
  logic       cnt_en;

  assign baud        = ctrl_q.rclk | ctrl_q.transmit_clock_select;
  assign down_count_enable        = mode_q[`MODE_DOWN_COUNT_ENABLE_BIT];
  assign capres      = mode_q[`MODE_CRST_BIT];
  assign reload_mode = baud | ~ctrl_q.cpsel;
  assign down_mode   = down_count_enable & ~baud & ~ctrl_q.cpsel;
  assign dir_up      = ~down_mode | pin_lvl_q[0];

  assign div_lim = baud ? `DIV_BAUD : (speed_q ? `DIV_FAST : `DIV_SLOW);

  assign tick_en = (div_q >= div_lim - 4'h1);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      div_q <= 4'h0;
    end
    else
    begin
      div_q <= tick_en ? 4'h0 : div_q + 4'h1;
    end
  end

  assign cnt_en = ctrl_q.run & ((baud | ~ctrl_q.cts) ? tick_en : pin_fall[1]);

  ////////////////////////////////////////////////////////////////////////
  // counting, overflow, capture and reload

  logic [15:0] cnt16;
  logic [15:0] cap16;
  logic        up_ovf;
  logic        dn_ovf;
  logic        ovf_evt;
  logic        baud_ovf;
  logic        trg_evt;
  logic        cap_evt;
  logic        rld_evt;

  assign cnt16    = cnt_q;
  assign cap16    = cap_q;
  assign up_ovf   = cnt_en & dir_up & (cnt16 == `CNT_ALL_ONES);
  assign dn_ovf   = cnt_en & ~dir_up & (cnt16 == cap16);
  assign ovf_evt  = up_ovf | dn_ovf;
  assign baud_ovf = ovf_evt & baud;
  assign trg_evt  = pin_fall[0] & ctrl_q.exen & ~baud & ~down_mode;
  assign cap_evt  = trg_evt & ctrl_q.cpsel;
  assign rld_evt  = trg_evt & ~ctrl_q.cpsel;

  always_comb
  begin
    cnt_d = cnt16;
    if (cnt_en)
    begin
      if (dir_up)
      begin
        cnt_d = (up_ovf & reload_mode) ? cap16 : cnt16 + 16'h0001;
      end
      else
      begin
        cnt_d = dn_ovf ? `CNT_ALL_ONES : cnt16 - 16'h0001;
      end
    end
    if (rld_evt)
    begin
      cnt_d = cap16;
    end
    if (cap_evt & capres)
    begin
      cnt_d = `CNT_ZERO;
    end
  end

  // software writes to a count byte take precedence over counting
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= `CNT_ZERO;
    end
    else
    begin
      cnt_q.lo <= wr_cnt_lo ? pwdata[7:0] : cnt_d.lo;
      cnt_q.hi <= wr_cnt_hi ? pwdata[7:0] : cnt_d.hi;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cap_q <= `CNT_ZERO;
    end
    else if (cap_evt)
    begin
      cap_q <= cnt16;
    end
    else
    begin
      if (wr_cap_lo)
      begin
        cap_q.lo <= pwdata[7:0];
      end
      if (wr_cap_hi)
      begin
        cap_q.hi <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control, mode and flags; a hardware set wins over a software clear

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= `CTRL_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_q <= pwdata[7:0];
      end
      if (ovf_evt & ~baud)
      begin
        ctrl_q.ovf <= 1'b1;
      end
      if (trg_evt | (ovf_evt & down_count_enable & ~baud))
      begin
        ctrl_q.ext <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mode_q   <= `MODE_RST;
      speed_q  <= 1'b0;
      irq_en_q <= 1'b0;
    end
    else
    begin
      if (wr_mode)
      begin
        mode_q <= pwdata[7:0] & `MODE_WR_MASK;
      end
      if (wr_clk)
      begin
        speed_q <= pwdata[`CLKCTL_SPD_BIT];
      end
      if (wr_irq)
      begin
        irq_en_q <= pwdata[`IRQEN_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial baud ticks and interrupt request

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rx_baud_tick <= 1'b0;
      tx_baud_tick <= 1'b0;
      timer_irq    <= 1'b0;
    end
    else
    begin
      rx_baud_tick <= serial_mode[0] & (ctrl_q.rclk ? baud_ovf : timer1_overflow);
      tx_baud_tick <= serial_mode[0] & (ctrl_q.transmit_clock_select ? baud_ovf : timer1_overflow);
      timer_irq    <= irq_en_q & (ctrl_q.ovf | ctrl_q.ext);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  overflow_sets_a: assert property (up_ovf & ~baud |=> ctrl_q.ovf)
    else $error("overflow did not set flag");
  down_equal_a: assert property (cnt_en & ~dir_up & (cnt16 == cap16) & ~baud
    |=> ctrl_q.ovf && cnt16 == `CNT_ALL_ONES)
    else $error("down count match missed");
  baud_no_flag_a: assert property (baud & ~ctrl_q.ovf & ~wr_ctrl
    |=> ~ctrl_q.ovf)
    else $error("overflow flag set in baud mode");
  flag_holds_a: assert property (ctrl_q.ovf & ~wr_ctrl |=> ctrl_q.ovf)
    else $error("overflow flag cleared by hardware");
  edge_flag_a: assert property (trg_evt |=> ctrl_q.ext [*1] ##0
    (ctrl_q.ext | $past(wr_ctrl)))
    else $error("event flag not set by trigger edge");
  irq_follow_a: assert property (ctrl_q.ext & irq_en_q |=> timer_irq)
    else $error("interrupt not raised");
  rx_source_a: assert property (serial_mode[0] & ~ctrl_q.rclk & timer1_overflow
    |=> rx_baud_tick)
    else $error("receive tick not from timer 1");
  tx_source_a: assert property (serial_mode[0] & ctrl_q.transmit_clock_select & baud_ovf
    |=> tx_baud_tick)
    else $error("transmit tick not from own overflow");
  halt_holds_a: assert property (~ctrl_q.run & ~trg_evt & ~wr_cnt_lo & ~wr_cnt_hi
    |=> $stable(cnt16))
    else $error("count moved while halted");
  baud_rate_a: assert property (baud & cnt_en & ~wr_ctrl & ~wr_clk
    |=> ~cnt_en ##1 (cnt_en | ~ctrl_q.run))
    else $error("baud rate not every two clocks");
  reload_a: assert property (up_ovf & reload_mode & ~rld_evt & ~wr_cnt_lo
    & ~wr_cnt_hi |=> cnt16 == $past(cap16))
    else $error("no reload on overflow");
  capture_a: assert property (cap_evt |=> cap16 == $past(cnt16))
    else $error("capture missed");
  capture_clear_a: assert property (cap_evt & capres & ~wr_cnt_lo & ~wr_cnt_hi
    |=> cnt16 == `CNT_ZERO)
    else $error("count not cleared after capture");

  capture_seen_c: cover property (cap_evt ##1 ctrl_q.ext);
  baud_tick_c: cover property (baud_ovf ##1 rx_baud_tick);
  down_ovf_c: cover property (dn_ovf ##1 ctrl_q.ovf);
  reload_edge_c: cover property (rld_evt);

endmodule

// >>> tmr2_far_side.sv
module tmr2_far_side (
  input  wire logic clk_sys, // system clock
  output logic      trig,    // trigger pin level
  output logic      cnt_pin, // count pin level
  output logic      t1_ovf   // timer 1 overflow pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins idle at their pull-up level
  initial
  begin
    trig = 1'b1;
    cnt_pin = 1'b1;
    t1_ovf = 1'b0;
  end
  task automatic set_trig(input logic lvl);
    @(posedge clk_sys);
    trig <= lvl;
  endtask
  // low phase long enough for the pin filter
  task automatic fall_trig();
    set_trig(1'b0);
    repeat (6) @(posedge clk_sys);
    trig <= 1'b1;
  endtask
  task automatic count_edges(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      cnt_pin <= 1'b0;
      repeat (5) @(posedge clk_sys);
      cnt_pin <= 1'b1;
      repeat (5) @(posedge clk_sys);
    end
  endtask
  task automatic t1_pulse();
    @(posedge clk_sys);
    t1_ovf <= 1'b1;
    @(posedge clk_sys);
    t1_ovf <= 1'b0;
  endtask
endmodule

// >>> tb.sv
`include "tmr2_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_CTRL = {2'b00, `IDX_CTRL, 2'b00};
  localparam logic [11:0] A_MODE = {2'b00, `IDX_MODE, 2'b00};
  localparam logic [11:0] A_CAPL = {2'b00, `IDX_CAP_LO, 2'b00};
  localparam logic [11:0] A_CAPH = {2'b00, `IDX_CAP_HI, 2'b00};
  localparam logic [11:0] A_CNTL = {2'b00, `IDX_CNT_LO, 2'b00};
  localparam logic [11:0] A_CNTH = {2'b00, `IDX_CNT_HI, 2'b00};
  localparam logic [11:0] A_CLK  = {2'b00, `IDX_CLKCTL, 2'b00};
  localparam logic [11:0] A_IRQ  = {2'b00, `IDX_IRQEN, 2'b00};
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [1:0]  serial_mode = 2'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        trig;
  logic        cnt_pin;
  logic        t1_ovf;
  logic        rx_tick;
  logic        tx_tick;
  logic        irq;
  logic [31:0] rd;
  logic [31:0] v;
  logic        err;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          rx_n = 0;
  int          tx_n = 0;
  timer2_capture_reload_baud i_dut (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_trigger_pin(trig), .external_count_pin(cnt_pin), .serial_mode(serial_mode),
    .timer1_overflow(t1_ovf), .rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick),
    .timer_irq(irq));
  tmr2_far_side i_far (.clk_sys(clk_sys), .trig(trig), .cnt_pin(cnt_pin), .t1_ovf(t1_ovf));
  always #10 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (fail_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  always @(posedge clk_sys)
  begin
    cycles++;
    if (rx_tick === 1'b1)
      rx_n++;
    if (tx_tick === 1'b1)
      tx_n++;
    if (cycles >= 20000)
    begin
      fail_count++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rd, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    v = $urandom(87);
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, 12'hFFC, 32'h00000000);
    chk({31'h0, err}, 32'h1);
    wr(A_CLK, 32'h20);
    wr(A_IRQ, 32'h20);
    wr(A_CTRL, 32'h80);
    rdchk(A_CTRL, 32'h80);
    wr(A_CTRL, 32'h00);
    rdchk(A_CTRL, 32'h00);
    // reload on overflow, reload low byte zero so the high byte is exact
    v = $urandom;
    wr(A_CAPH, {24'h0, v[7:0]});
    wr(A_CAPL, 32'h00);
    wr(A_CNTH, 32'hFF);
    wr(A_CNTL, 32'hFE);
    wr(A_CTRL, 32'h04);
    repeat (20) @(posedge clk_sys);
    rdchk(A_CTRL, 32'h84);
    wr(A_CTRL, 32'h00);
    rdchk(A_CNTH, {24'h0, v[7:0]});
    apb(1'b0, A_CNTL, 32'h00000000);
    v[15:8] = rd[7:0];
    repeat (20) @(posedge clk_sys);
    rdchk(A_CNTL, {24'h0, v[15:8]});
    // down count to the reload value, then up with the trigger high
    v = $urandom;
    i_far.set_trig(1'b0);
    wr(A_MODE, 32'h01);
    wr(A_CAPH, {24'h0, v[7:0]});
    wr(A_CAPL, 32'h10);
    wr(A_CNTH, {24'h0, v[7:0]});
    wr(A_CNTL, 32'h12);
    wr(A_CTRL, 32'h04);
    repeat (30) @(posedge clk_sys);
    rdchk(A_CTRL, 32'hC4);
    rdchk(A_CNTH, 32'hFF);
    i_far.set_trig(1'b1);
    wr(A_CNTH, 32'h00);
    wr(A_CNTL, 32'h00);
    repeat (30) @(posedge clk_sys);
    rdchk(A_CNTH, 32'h00);
    wr(A_MODE, 32'h08);
    // capture with reset, count pin idle so the count stands still
    v = $urandom;
    wr(A_CTRL, 32'h0F);
    wr(A_CNTH, {24'h0, v[15:8]});
    wr(A_CNTL, {24'h0, v[7:0]});
    i_far.fall_trig();
    repeat (6) @(posedge clk_sys);
    rdchk(A_CAPL, {24'h0, v[7:0]});
    rdchk(A_CAPH, {24'h0, v[15:8]});
    rdchk(A_CNTL, 32'h00);
    rdchk(A_CNTH, 32'h00);
    rdchk(A_CTRL, 32'h4F);
    chk({31'h0, irq}, 32'h1);
    // trigger ignored without external enable, pin edges counted
    wr(A_CTRL, 32'h07);
    wr(A_CNTL, {24'h0, v[23:16]});
    i_far.fall_trig();
    i_far.count_edges(5);
    rdchk(A_CTRL, 32'h07);
    rdchk(A_CAPL, {24'h0, v[7:0]});
    rdchk(A_CNTL, {24'h0, v[23:16] + 8'h05});
    // baud generation: 16 steps of 2 clocks between overflows
    wr(A_CAPH, 32'hFF);
    wr(A_CAPL, 32'hF0);
    wr(A_CNTH, 32'hFF);
    wr(A_CNTL, 32'hF0);
    serial_mode <= 2'h1;
    wr(A_CTRL, 32'h25);
    rx_n = 0;
    tx_n = 0;
    repeat (3) i_far.t1_pulse();
    repeat (314) @(posedge clk_sys);
    chk(32'(rx_n >= 9 && rx_n <= 11), 32'h1);
    chk(32'(tx_n), 32'h3);
    rdchk(A_CTRL, 32'h25);
    // transmit from own overflow, receive back on timer 1
    wr(A_CTRL, 32'h15);
    repeat (2) @(posedge clk_sys);
    rx_n = 0;
    tx_n = 0;
    repeat (2) i_far.t1_pulse();
    repeat (316) @(posedge clk_sys);
    chk(32'(rx_n), 32'h2);
    chk(32'(tx_n >= 9 && tx_n <= 11), 32'h1);
    rdchk(A_CTRL, 32'h15);
    // slow internal ticks: 120 clocks of running give exactly ten steps
    wr(A_CTRL, 32'h00);
    wr(A_CLK, 32'h00);
    wr(A_CNTH, 32'h00);
    wr(A_CNTL, 32'h00);
    wr(A_CTRL, 32'h04);
    repeat (118) @(posedge clk_sys);
    wr(A_CTRL, 32'h00);
    rdchk(A_CNTL, 32'h0A);
    // trigger edge reloads from the capture bytes while halted
    wr(A_CTRL, 32'h08);
    i_far.fall_trig();
    repeat (6) @(posedge clk_sys);
    rdchk(A_CNTL, 32'hF0);
    rdchk(A_CNTH, 32'hFF);
    rdchk(A_CTRL, 32'h48);
    conclude();
  end
endmodule
